//--- design/crb_top.sv
// CAN receive buffers, acceptance filter high bytes and receive fault state
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module crb_top (
  input wire logic clk, // System clock, 25 MHz
  input wire logic rst_b, // Async reset, active low
  input wire crb_pkg::crb_avs_req_t avs, // Avalon request
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon waitrequest
  input wire crb_pkg::crb_frame_t frame, // Frame from receive engine
  input wire crb_pkg::crb_rec_ev_t rec_ev, // Receive fault events
  input wire logic tx_passive, // Transmit side wants passive
  input wire crb_pkg::crb_id_t id_in, // Identifier to check
  output logic [crb_pkg::NFILT-1:0] accept, // Filter hits
  output logic err_passive, // Error-passive state
  output logic irq // Interrupt, active high
);
  import crb_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  crb_bus_t state_q;
  logic [7:0] pay_q [NBUF][NBYTE];
  logic [3:0] len_q [NBUF];
  logic [7:0] fid_q [NFILT];
  logic [NFILT-1:0] ext_only_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_set;
  logic [7:0] rec_cnt;
  logic rx_pass;
  logic wr_fire;
  logic [7:0] a;
  logic [31:0] rd_d;
  logic pass_d;

  // Byte count a length code stands for
  function automatic logic [3:0] dlc_len(input logic [3:0] dlc);
    return (dlc > LEN_MAX) ? LEN_MAX : dlc;
  endfunction

  // Identifier bits that meet the filter high byte
  function automatic logic [7:0] id_top(input crb_id_t x);
    return x.ext ? x.id[28:21] : x.id[10:3];
  endfunction

  assign a = avs.address;
  assign wr_fire = avs.write && (state_q == BUS_ANS);
  assign pass_d = rx_pass || tx_passive;

  // ----------------------------------------
  // Fault counter
  // ----------------------------------------
  crb_rec u_rec (
    .clk(clk),
    .rst_b(rst_b),
    .ev(rec_ev),
    .cnt_q(rec_cnt),
    .rx_pass(rx_pass)
  );

  // ----------------------------------------
  // Avalon slave handshake
  // ----------------------------------------
  // One idle cycle, then waitrequest low for one cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (state_q)
        BUS_IDLE: begin
          if (avs.read || avs.write) begin
            state_q <= BUS_ANS;
            avs_waitrequest <= 1'b0;
          end
        end
        BUS_ANS: begin
          state_q <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          state_q <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Read decode
  always_comb begin
    rd_d = RD_UNMAPPED;
    if (a < OFF_LEN0) begin
      rd_d = {24'h0, pay_q[a[5]][a[4:2]]};
    end else if (a == OFF_LEN0) begin
      rd_d = {28'h0, len_q[0]};
    end else if (a == OFF_LEN1) begin
      rd_d = {28'h0, len_q[1]};
    end else if (a == OFF_REC) begin
      rd_d = {24'h0, rec_cnt};
    end else if (a == OFF_FID0) begin
      rd_d = {24'h0, fid_q[0]};
    end else if (a == OFF_FID1) begin
      rd_d = {24'h0, fid_q[1]};
    end else if (a == OFF_FCT0) begin
      rd_d = {31'h0, ext_only_q[0]};
    end else if (a == OFF_FCT1) begin
      rd_d = {31'h0, ext_only_q[1]};
    end else if (a == OFF_STAT) begin
      rd_d = {30'h0, rx_pass, err_passive};
    end else if (a == OFF_IRQS) begin
      rd_d = {29'h0, irq_stat_q};
    end else if (a == OFF_IRQM) begin
      rd_d = {29'h0, irq_mask_q};
    end
  end

  // Read data latched as waitrequest drops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= RD_UNMAPPED;
    end else if (state_q == BUS_IDLE && avs.read) begin
      avs_readdata <= rd_d;
    end
  end

  // ----------------------------------------
  // Receive buffers
  // ----------------------------------------
  // Software writes, then frame store, which wins on a clash
  // payload byte array
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int b = 0; b < NBUF; b++) begin
        for (int i = 0; i < NBYTE; i++) begin
          pay_q[b][i] <= RST_BYTE;
        end
      end
    end else begin
      if (wr_fire && a < OFF_LEN0) begin
        pay_q[a[5]][a[4:2]] <= avs.writedata[7:0];
      end
      if (frame.store) begin
        for (int i = 0; i < NBYTE; i++) begin
          if (4'(i) < dlc_len(frame.dlc)) begin
            pay_q[frame.buf_sel][i] <= frame.data[i*8 +: 8];
          end
        end
      end
    end
  end

  // Length registers keep the code as received
  // code in bits 3..0
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      len_q[0] <= RST_LEN;
      len_q[1] <= RST_LEN;
    end else begin
      if (wr_fire && a == OFF_LEN0) begin
        len_q[0] <= avs.writedata[LEN_POS +: 4];
      end
      if (wr_fire && a == OFF_LEN1) begin
        len_q[1] <= avs.writedata[LEN_POS +: 4];
      end
      if (frame.store) begin
        len_q[frame.buf_sel] <= frame.dlc;
      end
    end
  end

  // ----------------------------------------
  // Acceptance filters
  // ----------------------------------------
  // high byte registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fid_q[0] <= RST_BYTE;
      fid_q[1] <= RST_BYTE;
      ext_only_q <= '0;
    end else if (wr_fire) begin
      if (a == OFF_FID0) begin
        fid_q[0] <= avs.writedata[7:0];
      end else if (a == OFF_FID1) begin
        fid_q[1] <= avs.writedata[7:0];
      end else if (a == OFF_FCT0) begin
        ext_only_q[0] <= avs.writedata[FCT_EXT_POS];
      end else if (a == OFF_FCT1) begin
        ext_only_q[1] <= avs.writedata[FCT_EXT_POS];
      end
    end
  end

  // Hit needs matching frame kind and high byte
  // kind selection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      accept <= '0;
    end else begin
      for (int f = 0; f < NFILT; f++) begin
        accept[f] <= id_in.check && (id_in.ext == ext_only_q[f]) && (id_top(id_in) == fid_q[f]);
      end
    end
  end

  // ----------------------------------------
  // Error state
  // ----------------------------------------
  // passive until both sides clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_passive <= 1'b0;
    end else begin
      err_passive <= pass_d;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // flag invalid codes
  assign irq_set = {frame.store && (frame.dlc > LEN_MAX), pass_d && !err_passive, frame.store};

  // Sticky status, write one clears, a new event wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_q <= RST_IRQ;
    end else if (wr_fire && a == OFF_IRQS) begin
      irq_stat_q <= (irq_stat_q & ~avs.writedata[2:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  // Mask register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_q <= RST_IRQ;
    end else if (wr_fire && a == OFF_IRQM) begin
      irq_mask_q <= avs.writedata[2:0];
    end
  end

  // Level interrupt from flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence store0_s;
    frame.store && !frame.buf_sel;
  endsequence

  len_store_a: assert property (store0_s |=> len_q[0] == $past(frame.dlc))
    else $error("length code not kept");
  bad_len_a: assert property (frame.store && frame.dlc > LEN_MAX |=> irq_stat_q[IRQ_BADLEN])
    else $error("invalid length not flagged");
  pay_first_a: assert property (store0_s ##0 frame.dlc != 4'h0 |=> pay_q[0][0] == $past(frame.data[7:0]))
    else $error("payload byte zero not stored");
  pay_last_a: assert property (store0_s ##0 frame.dlc < LEN_MAX && !wr_fire |=> $stable(pay_q[0][7]))
    else $error("byte past length overwritten");
  rec_read_a: assert property (state_q == BUS_IDLE && avs.read && a == OFF_REC |=>
    avs_readdata == {24'h0, $past(rec_cnt)} ##1 avs_waitrequest)
    else $error("counter read wrong");
  enter_pass_a: assert property (rec_cnt > REC_PASSIVE && !err_passive |=>
    err_passive && irq_stat_q[IRQ_PASSIVE])
    else $error("passive not entered");
  leave_pass_a: assert property (rec_cnt <= REC_PASSIVE && !tx_passive |=> !err_passive)
    else $error("passive not left");
  filt_hit_a: assert property (id_in.check && id_in.ext == ext_only_q[0] && id_top(id_in) == fid_q[0]
    |=> accept[0])
    else $error("filter missed");
  filt_kind_a: assert property (id_in.ext != ext_only_q[0] |=> !accept[0])
    else $error("filter took wrong kind");
  irq_lvl_a: assert property ((irq_stat_q & irq_mask_q) != 3'h0 |=> irq)
    else $error("interrupt missing");

  // Bus access taken while idle, answered for one cycle, then back at rest
  sequence bus_take_s;
    state_q == BUS_IDLE && (avs.read || avs.write);
  endsequence

  sequence bus_answer_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  bus_answer_a: assert property (bus_take_s |=> bus_answer_s)
    else $error("bus answer not one cycle long");

  // Counter ignores software writes
  // read-only counter
  rec_ro_a: assert property (wr_fire && a == OFF_REC && rec_ev == 3'h0 |=> $stable(rec_cnt))
    else $error("fault counter took a write");

  // Buffer one keeps its code and first byte as received
  // buffer one length
  len_store1_a: assert property (frame.store && frame.buf_sel |=> len_q[1] == $past(frame.dlc))
    else $error("length code of buffer one not kept");
  pay1_first_a: assert property (frame.store && frame.buf_sel && frame.dlc != 4'h0 |=>
    pay_q[1][0] == $past(frame.data[7:0]))
    else $error("buffer one byte zero not stored");

  // Filter byte and kind bit take what software writes
  // filter byte write
  fid_wr_a: assert property (wr_fire && a == OFF_FID1 |=> fid_q[1] == $past(avs.writedata[7:0]))
    else $error("filter byte not written");
  ext_wr_a: assert property (wr_fire && a == OFF_FCT1 |=>
    ext_only_q[1] == $past(avs.writedata[FCT_EXT_POS]))
    else $error("extended-only bit not written");

  // Error state follows both sides one cycle later
  // follow both sides
  err_follow_a: assert property (err_passive == $past(pass_d))
    else $error("error state lags wrongly");

  // Write one clears a status bit when no new event sets it
  w1c_a: assert property (wr_fire && a == OFF_IRQS && irq_set == 3'h0 |=>
    irq_stat_q == ($past(irq_stat_q) & ~$past(avs.writedata[2:0])))
    else $error("status clear wrong");

  // Mask takes the written bits
  mask_wr_a: assert property (wr_fire && a == OFF_IRQM |=> irq_mask_q == $past(avs.writedata[2:0]))
    else $error("mask not written");

  // No unmasked status bit, no interrupt
  irq_off_a: assert property ((irq_stat_q & irq_mask_q) == 3'h0 |=> !irq)
    else $error("interrupt without cause");
endmodule // crb_top

//--- include/crb_pkg.sv
// Constants and types for the CAN receive buffer and fault counter block
//
// Operation
// - Length code 0..8 gives that many payload bytes; codes 9..15 are invalid.
// - Each receive buffer holds eight separate 8-bit payload byte registers, 0..7.
// - Receive fault counter is 8-bit, read-only, follows network rules, resets to zero.
// - Counter above 127 puts the block into the error-passive state.
// - The receive fault counter never causes bus-off, however high it climbs.
// - Filter high identifier byte is 8-bit RW: std bits 10..3 or ext 28..21.
// - Length code sits in bits 3..0 of each buffer length register.
// - Filter extended-only bit: set accepts only extended, clear only standard frames.
package crb_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NBUF = 2;
  localparam int NBYTE = 8;
  localparam int NFILT = 2;
  localparam logic [3:0] LEN_MAX = 4'h8;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_PAY0 = 8'h00; // buffer 0 bytes 0..7, buffer 1 at +0x20
  localparam logic [7:0] OFF_LEN0 = 8'h40;
  localparam logic [7:0] OFF_LEN1 = 8'h44;
  localparam logic [7:0] OFF_REC = 8'h48;
  localparam logic [7:0] OFF_FID0 = 8'h4C;
  localparam logic [7:0] OFF_FID1 = 8'h50;
  localparam logic [7:0] OFF_FCT0 = 8'h54;
  localparam logic [7:0] OFF_FCT1 = 8'h58;
  localparam logic [7:0] OFF_STAT = 8'h5C;
  localparam logic [7:0] OFF_IRQS = 8'h60;
  localparam logic [7:0] OFF_IRQM = 8'h64;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int LEN_POS = 0;
  localparam int FCT_EXT_POS = 0;
  localparam int STAT_PASS_POS = 0;
  localparam int STAT_RXP_POS = 1;
  localparam int IRQ_STORED = 0;
  localparam int IRQ_PASSIVE = 1;
  localparam int IRQ_BADLEN = 2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_LEN = 4'h0;
  localparam logic [7:0] RST_REC = 8'h00;
  localparam logic [2:0] RST_IRQ = 3'h0;
  localparam logic [7:0] REC_PASSIVE = 8'h7F;
  localparam logic [7:0] REC_RESUME = 8'h77;
  localparam logic [7:0] REC_MAX = 8'hFF;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } crb_avs_req_t;

  typedef struct packed {
    logic store;
    logic buf_sel;
    logic [3:0] dlc;
    logic [63:0] data;
  } crb_frame_t;

  typedef struct packed {
    logic inc1;
    logic inc8;
    logic dec;
  } crb_rec_ev_t;

  typedef struct packed {
    logic check;
    logic ext;
    logic [28:0] id;
  } crb_id_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANS = 2'b10
  } crb_bus_t;
endpackage

//--- design/crb_rec.sv
// Receive fault counter with saturation and passive threshold
`timescale 1ns/100ps
module crb_rec (
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire crb_pkg::crb_rec_ev_t ev, // Counting events
  output logic [7:0] cnt_q, // Counter value
  output logic rx_pass // Counter above threshold
);
  import crb_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Saturating add, no wrap past the top
  // no wrap, no bus-off
  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[8] ? REC_MAX : s[7:0];
  endfunction

  // Counter update
  // network counting
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= RST_REC;
    end else if (ev.inc8) begin
      cnt_q <= sat_add(cnt_q, 8'h08);
    end else if (ev.inc1) begin
      cnt_q <= sat_add(cnt_q, 8'h01);
    end else if (ev.dec) begin
      if (cnt_q > REC_PASSIVE) begin
        cnt_q <= REC_RESUME;
      end else if (cnt_q != RST_REC) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  assign rx_pass = (cnt_q > REC_PASSIVE);

  cnt_stable_a: assert property (!ev.inc1 && !ev.inc8 && !ev.dec |=> $stable(cnt_q))
    else $error("fault counter moved without an event");
  cnt_sat_a: assert property (cnt_q == REC_MAX && (ev.inc8 || ev.inc1) |=> cnt_q == REC_MAX)
    else $error("fault counter wrapped");
  cnt_inc8_a: assert property (ev.inc8 && cnt_q < 8'hF0 |=> cnt_q == $past(cnt_q) + 8'h08)
    else $error("fault counter did not add eight");
endmodule // crb_rec

//--- tb/crb_node_model.sv
// Model of the remote bus nodes feeding frames, fault events and identifiers
`timescale 1ns/100ps
module crb_node_model (
  input wire logic clk, // System clock
  output crb_pkg::crb_frame_t frame, // Received frame to store
  output crb_pkg::crb_rec_ev_t rec_ev, // Receive fault events
  output crb_pkg::crb_id_t id_in // Identifier to test
);
  import crb_pkg::*;

  // Lines idle at time zero
  initial begin
    frame = '0;
    rec_ev = '0;
    id_in = '0;
  end

  // One stored frame; released lines show the inverse so stale data is never reused
  task automatic send(input logic b, input logic [3:0] code, input logic [63:0] d);
    @(posedge clk);
    frame <= '{store: 1'b1, buf_sel: b, dlc: code, data: d};
    @(posedge clk);
    frame <= '{store: 1'b0, buf_sel: ~b, dlc: ~code, data: ~d};
  endtask

  // Fault event held for n edges, one count per edge
  task automatic events(input crb_rec_ev_t e, input int n);
    @(posedge clk);
    rec_ev <= e;
    repeat (n) @(posedge clk);
    rec_ev <= '0;
  endtask

  // One identifier to match against the filters
  task automatic probe(input logic x, input logic [28:0] v);
    @(posedge clk);
    id_in <= '{check: 1'b1, ext: x, id: v};
    @(posedge clk);
    id_in <= '{check: 1'b0, ext: ~x, id: ~v};
  endtask
endmodule // crb_node_model

//--- tb/crb_top_tb.sv
// Self-checking bench for the receive buffers, filter bytes and fault counter
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module crb_top_tb;
  import crb_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam crb_rec_ev_t INC1 = 3'b100;
  localparam crb_rec_ev_t INC8 = 3'b010;
  localparam crb_rec_ev_t DEC = 3'b001;
  localparam logic [63:0] PAT = 64'h8877_6655_4433_2211;
  logic clk;
  logic rst_b;
  crb_avs_req_t avs;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  crb_frame_t frame;
  crb_rec_ev_t rec_ev;
  logic tx_passive;
  crb_id_t id_in;
  logic [NFILT-1:0] accept;
  logic err_passive;
  logic irq;
  int fail_count;
  int tests_run;
  logic [31:0] rd;
  logic [63:0] pay;
  logic irq_on;

  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  crb_top uut (.clk(clk), .rst_b(rst_b), .avs(avs), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .frame(frame), .rec_ev(rec_ev), .tx_passive(tx_passive),
    .id_in(id_in), .accept(accept), .err_passive(err_passive), .irq(irq));
  crb_node_model node (.clk(clk), .frame(frame), .rec_ev(rec_ev), .id_in(id_in));

  // Clock at 25 MHz
  always #20 clk = ~clk;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // One bus access, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs <= '{read: ~w, write: w, address: a, writedata: d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e);
  endtask

  // Identifier test, filter result looked at in the one cycle it stands
  task automatic probe_chk(input logic x, input logic [28:0] v, input logic [NFILT-1:0] e);
    node.probe(x, v);
    @(negedge clk);
    `CHK(accept, e);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #(40 * 20000);
    fail_count++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    avs = '0;
    tx_passive = 1'b0;
    fail_count = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    `CHK({err_passive, irq, avs_waitrequest}, 3'b001);
    rd_chk(OFF_REC, 32'h0);
    bus(1'b1, OFF_REC, 32'h55);
    rd_chk(OFF_REC, 32'h0);
    bus(1'b1, 8'h7C, 32'hFF);
    rd_chk(8'h7C, RD_UNMAPPED);
    bus(1'b1, OFF_FID0, 32'hA5);
    bus(1'b1, OFF_FID1, 32'h3C);
    bus(1'b1, OFF_FCT0, 32'h1);
    bus(1'b1, OFF_FCT1, 32'h0);
    rd_chk(OFF_FID0, 32'hA5);
    rd_chk(OFF_FID1, 32'h3C);
    rd_chk(OFF_FCT0, 32'h1);
    probe_chk(1'b1, {8'hA5, 21'h0ABCD}, 2'b01);
    probe_chk(1'b0, {18'h0, 8'h3C, 3'h5}, 2'b10);
    probe_chk(1'b0, {18'h0, 8'hA5, 3'h0}, 2'b00);
    probe_chk(1'b1, {8'h3C, 21'h0}, 2'b00);
    for (int b = 0; b < NBUF; b++) begin
      pay = PAT + 64'(b);
      node.send(b[0], LEN_MAX, pay);
      for (int i = 0; i < NBYTE; i++) begin
        rd_chk(OFF_PAY0 + 8'(32 * b + 4 * i), {24'h0, pay[8 * i +: 8]});
      end
    end
    // every length code, invalid ones flagged
    for (int c = 0; c < 16; c++) begin
      node.send(c[0], c[3:0], 64'h0);
      rd_chk(c[0] ? OFF_LEN1 : OFF_LEN0, 32'(c));
      rd_chk(OFF_IRQS, (c > 8) ? 32'h5 : 32'h1);
    end
    // Mask flips the interrupt, clearing empties the status while masked
    bus(1'b1, OFF_IRQM, 32'h7);
    repeat (2) @(negedge clk);
    irq_on = irq;
    bus(1'b1, OFF_IRQM, 32'h0);
    repeat (2) @(negedge clk);
    `CHK(irq_on, 1'b1);
    `CHK(irq, 1'b0);
    bus(1'b1, OFF_IRQS, 32'h7);
    repeat (2) @(negedge clk);
    rd_chk(OFF_IRQS, 32'h0);
    `CHK(irq, 1'b0);
    // threshold crossed at 128, not at 127
    node.events(INC8, 15);
    node.events(INC1, 7);
    rd_chk(OFF_REC, 32'd127);
    `CHK(err_passive, 1'b0);
    node.events(INC1, 1);
    rd_chk(OFF_REC, 32'd128);
    `CHK(err_passive, 1'b1);
    rd_chk(OFF_STAT, 32'h3);
    rd_chk(OFF_IRQS, 32'h2);
    // leave passive unless transmit side holds it
    node.events(DEC, 1);
    rd_chk(OFF_REC, {24'h0, REC_RESUME});
    `CHK(err_passive, 1'b0);
    @(posedge clk);
    tx_passive <= 1'b1;
    repeat (2) @(negedge clk);
    `CHK(err_passive, 1'b1);
    @(posedge clk);
    tx_passive <= 1'b0;
    node.events(INC8, 40);
    rd_chk(OFF_REC, {24'h0, REC_MAX});
    `CHK(err_passive, 1'b1);
    tally_and_finish();
  end
endmodule // crb_top_tb
